// file: hw/rsmc_regs.vh
`ifndef RSMC_REGS_VH
`define RSMC_REGS_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define RSMC_ADDR_W        8
`define RSMC_OFS_CONFIG    8'h00
`define RSMC_OFS_STATUS    8'h04
`define RSMC_OFS_PINS      8'h08

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RSMC_BIT_MUXBUS    0
`define RSMC_BIT_BIGEND    1
`define RSMC_BIT_SBOOT     2
`define RSMC_BIT_BKMODE    0
`define RSMC_BIT_BKRST     1
`define RSMC_BIT_BUSPIN    0
`define RSMC_BIT_ENDPIN    1
`define RSMC_BIT_BOOTPIN   2

// ----------------------------------------------------------------
// Synchronised pin indices
// ----------------------------------------------------------------
`define RSMC_PIN_BUS       0
`define RSMC_PIN_END       1
`define RSMC_PIN_BOOT      2
`define RSMC_PIN_BKRST     3
`define RSMC_PIN_BKTRIG    4

// ----------------------------------------------------------------
// Reset values and responses
// ----------------------------------------------------------------
`define RSMC_CFG_RST       3'h0
`define RSMC_RESP_OKAY     2'h0
`define RSMC_RESP_SLVERR   2'h2
`define RSMC_ZERO32        32'h0000_0000

`endif

// file: hw/rsmc_strap_capture.v
// Summary of operation
// - Main reset returns all logic except the pin synchronisers to initial state
// - Backup reset initialises only backup logic
// - Bus strap high selects multiplexed bus
// - Bus strap low selects separate buses
// - Byte-order strap high selects big endian
// - Boot strap low selects single boot
// - Boot strap high selects normal start
`timescale 1ns/1ps
`default_nettype none
`include "rsmc_regs.vh"

module rsmc_strap_capture (
    input  wire        sys_clk,
    input  wire        reset,
    input  wire        backup_module_reset,
    input  wire        bus_mode_strap,
    input  wire        endian_strap,
    input  wire        boot_select_strap,
    input  wire        backup_mode_trigger,
// ----------------------------------------------------------------
// Configuration and status outputs
// ----------------------------------------------------------------
    output reg         mux_bus_ff,
    output reg         big_endian_ff,
    output reg         single_boot_ff,
    output reg         backup_mode_ff,
    output reg         backup_reset_ff,
// ----------------------------------------------------------------
// AXI4-Lite register bus
// ----------------------------------------------------------------
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output reg         s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output reg         s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output reg         s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

// ----------------------------------------------------------------
// Pin synchronisers, three stages each
// ----------------------------------------------------------------
    localparam NPIN = 5;
    wire [NPIN-1:0] pin_in;
    reg  [NPIN-1:0] s1_ff;
    reg  [NPIN-1:0] s2_ff;
    reg  [NPIN-1:0] s3_ff;
    reg  [NPIN-1:0] pin_ff;
    assign pin_in = {backup_mode_trigger, backup_module_reset,
                     boot_select_strap, endian_strap, bus_mode_strap};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
            always @(posedge sys_clk) begin
                s1_ff[gi] <= pin_in[gi];
                s2_ff[gi] <= s1_ff[gi];
                s3_ff[gi] <= s2_ff[gi];
                if (s2_ff[gi] == s3_ff[gi]) begin
                    pin_ff[gi] <= s3_ff[gi];
                end
            end
        end
    endgenerate

// ----------------------------------------------------------------
// Reset release detect
// ----------------------------------------------------------------
    reg rst_d_ff;
    always @(posedge sys_clk) begin
        rst_d_ff <= reset;
    end

// ----------------------------------------------------------------
// Strap capture at reset release
// ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            mux_bus_ff     <= 1'b0;
            big_endian_ff  <= 1'b0;
            single_boot_ff <= 1'b0;
        end else if (rst_d_ff) begin
            mux_bus_ff     <= pin_ff[`RSMC_PIN_BUS];
            big_endian_ff  <= pin_ff[`RSMC_PIN_END];
            single_boot_ff <= ~pin_ff[`RSMC_PIN_BOOT];
        end
    end

// ----------------------------------------------------------------
// Backup reset status
// ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            backup_reset_ff <= 1'b0;
        end else begin
            backup_reset_ff <= ~pin_ff[`RSMC_PIN_BKRST];
        end
    end

// ----------------------------------------------------------------
// Backup mode status
// ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            backup_mode_ff <= 1'b0;
        end else if (~pin_ff[`RSMC_PIN_BKRST]) begin
            backup_mode_ff <= 1'b0;
        end else begin
            backup_mode_ff <= ~pin_ff[`RSMC_PIN_BKTRIG];
        end
    end

// ----------------------------------------------------------------
// AXI4-Lite write channel, read-only map
// ----------------------------------------------------------------
    reg aw_got_ff;
    reg w_got_ff;
    reg wr_bad_ff;

// ----------------------------------------------------------------
// Write handshake and error response
// ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RSMC_RESP_OKAY;
            aw_got_ff     <= 1'b0;
            w_got_ff      <= 1'b0;
            wr_bad_ff     <= 1'b0;
        end else begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            if (s_axi_awvalid && !aw_got_ff && !s_axi_awready && !s_axi_bvalid) begin
                s_axi_awready <= 1'b1;
                aw_got_ff     <= 1'b1;
                wr_bad_ff     <= 1'b1;
            end
            if (s_axi_wvalid && !w_got_ff && !s_axi_wready && !s_axi_bvalid) begin
                s_axi_wready <= 1'b1;
                w_got_ff     <= 1'b1;
            end
            if (aw_got_ff && w_got_ff && !s_axi_bvalid) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_bad_ff ? `RSMC_RESP_SLVERR : `RSMC_RESP_OKAY;
                aw_got_ff    <= 1'b0;
                w_got_ff     <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

// ----------------------------------------------------------------
// AXI4-Lite read channel
// ----------------------------------------------------------------
    reg [31:0] nxt_rdata;
    reg        nxt_rbad;
    always @* begin
        nxt_rdata = `RSMC_ZERO32;
        nxt_rbad  = 1'b0;
        case (s_axi_araddr)
            `RSMC_OFS_CONFIG: begin
                nxt_rdata[`RSMC_BIT_MUXBUS] = mux_bus_ff;
                nxt_rdata[`RSMC_BIT_BIGEND] = big_endian_ff;
                nxt_rdata[`RSMC_BIT_SBOOT]  = single_boot_ff;
            end
            `RSMC_OFS_STATUS: begin
                nxt_rdata[`RSMC_BIT_BKMODE] = backup_mode_ff;
                nxt_rdata[`RSMC_BIT_BKRST]  = backup_reset_ff;
            end
            `RSMC_OFS_PINS: begin
                nxt_rdata[`RSMC_BIT_BUSPIN]  = pin_ff[`RSMC_PIN_BUS];
                nxt_rdata[`RSMC_BIT_ENDPIN]  = pin_ff[`RSMC_PIN_END];
                nxt_rdata[`RSMC_BIT_BOOTPIN] = pin_ff[`RSMC_PIN_BOOT];
            end
            default: begin
                nxt_rbad = 1'b1;
            end
        endcase
    end

// ----------------------------------------------------------------
// AXI4-Lite read response
// ----------------------------------------------------------------
    always @(posedge sys_clk) begin
        if (reset) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= `RSMC_ZERO32;
            s_axi_rresp   <= `RSMC_RESP_OKAY;
        end else begin
            s_axi_arready <= 1'b0;
            if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
                s_axi_arready <= 1'b1;
                s_axi_rvalid  <= 1'b1;
                s_axi_rdata   <= nxt_rdata;
                s_axi_rresp   <= nxt_rbad ? `RSMC_RESP_SLVERR : `RSMC_RESP_OKAY;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule // rsmc_strap_capture
`default_nettype wire

// file: bench/rsmc_board.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Board straps and reset source
// ----
module rsmc_board (
    input  wire logic sys_clk,
    output logic      reset,
    output logic      bus_mode_strap,
    output logic      endian_strap,
    output logic      boot_select_strap,
    output logic      backup_mode_trigger,
    output logic      backup_module_reset
);
    initial begin
        {reset, bus_mode_strap, endian_strap, boot_select_strap} = 4'hf;
        {backup_mode_trigger, backup_module_reset} = 2'h3;
    end
    task automatic straps(input logic [2:0] s);
        @(posedge sys_clk);
        {boot_select_strap, endian_strap, bus_mode_strap} <= s;
    endtask
    task automatic boot(input logic [2:0] s);
        straps(s);
        reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
    endtask
    task automatic backup(input logic trig, input logic rst_n);
        @(posedge sys_clk);
        backup_mode_trigger <= trig;
        backup_module_reset <= rst_n;
    endtask
endmodule // rsmc_board
`default_nettype wire

// file: bench/rsmc_chk.sv
`timescale 1ns/1ps
`default_nettype none
// ----
// Strap capture checks
// ----
module rsmc_chk (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic backup_module_reset,
    input wire logic bus_mode_strap,
    input wire logic endian_strap,
    input wire logic boot_select_strap,
    input wire logic backup_mode_trigger,
    input wire logic mux_bus_ff,
    input wire logic big_endian_ff,
    input wire logic single_boot_ff,
    input wire logic backup_mode_ff,
    input wire logic backup_reset_ff,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_rvalid
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence s_bk; (!backup_mode_trigger && backup_module_reset) [*8]; endsequence
    property p_mux; $fell(reset) |=> mux_bus_ff == $past(bus_mode_strap, 4); endproperty
    property p_end; $fell(reset) |=> big_endian_ff == $past(endian_strap, 4); endproperty
    property p_boot; $fell(reset) |=> single_boot_ff != $past(boot_select_strap, 4); endproperty
    property p_hold; !$fell(reset) |=> $stable({mux_bus_ff, big_endian_ff, single_boot_ff});
    endproperty
    property p_rst; disable iff (1'b0) reset |=> !(mux_bus_ff || big_endian_ff ||
        single_boot_ff || backup_mode_ff || backup_reset_ff || s_axi_bvalid || s_axi_rvalid);
    endproperty
    property p_bkr; !backup_module_reset [*8] |-> backup_reset_ff; endproperty
    property p_bkm; s_bk |-> backup_mode_ff; endproperty
    property p_bki; backup_mode_trigger [*8] |-> !backup_mode_ff; endproperty
    a_mux: assert property (p_mux) else $error("bus mode capture wrong");
    a_end: assert property (p_end) else $error("byte order capture wrong");
    a_boot: assert property (p_boot) else $error("boot mode capture wrong");
    a_hold: assert property (p_hold) else $error("config changed");
    a_rst: assert property (p_rst) else $error("outputs not cleared");
    a_bkr: assert property (p_bkr) else $error("backup reset missed");
    a_bkm: assert property (p_bkm) else $error("backup mode missed");
    a_bki: assert property (p_bki) else $error("backup mode stuck");
endmodule // rsmc_chk
bind rsmc_strap_capture rsmc_chk u_chk (.*);
`default_nettype wire

// file: bench/reset_strap_mode_capture_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "rsmc_regs.vh"
module reset_strap_mode_capture_tb_top;
    logic        sys_clk = 1'b0, reset, bus_mode_strap, endian_strap, boot_select_strap;
    logic        backup_mode_trigger, backup_module_reset, mux_bus_ff, big_endian_ff;
    logic        single_boot_ff, backup_mode_ff, backup_reset_ff, s_axi_awready, s_axi_wready;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0007, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_bvalid;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_arready, s_axi_rvalid;
    int          error_cnt = 0, checked = 0;
    rsmc_strap_capture uut (.*);
    rsmc_board brd (.*);
    always #2.5 sys_clk = ~sys_clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cfg(input logic [31:0] e);
        chk("cfg", e, {29'h0, single_boot_ff, big_endian_ff, mux_bus_ff});
    endtask
    task automatic bk(input logic [31:0] e);
        chk("backup", e, {30'h0, backup_reset_ff, backup_mode_ff});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ar_ok;
        n = 0;
        ar_ok = 1'b0;
        @(posedge sys_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_arready === 1'b1) begin
                s_axi_arvalid <= 1'b0;
                ar_ok = 1'b1;
            end
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        chk("arready", 32'h0000_0001, {31'h0, ar_ok});
        chk("rvalid", 32'h0000_0001, {31'h0, s_axi_rvalid});
        chk("rdata", ed, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    endtask
    task automatic t_cfg;
        for (int i = 0; i < 8; i++) begin
            brd.boot(i[2:0]);
            repeat (2) @(posedge sys_clk);
            cfg({29'h0, ~i[2], i[1:0]});
            rd(`RSMC_OFS_CONFIG, {29'h0, ~i[2], i[1:0]}, `RSMC_RESP_OKAY);
        end
    endtask
    task automatic t_hold;
        brd.boot(3'h5);
        repeat (2) @(posedge sys_clk);
        brd.straps(3'h2);
        repeat (10) @(posedge sys_clk);
        cfg(32'h0000_0001);
        rd(`RSMC_OFS_PINS, 32'h0000_0002, `RSMC_RESP_OKAY);
    endtask
    task automatic t_bk;
        brd.backup(1'b0, 1'b1);
        repeat (10) @(posedge sys_clk);
        rd(`RSMC_OFS_STATUS, 32'h0000_0001, `RSMC_RESP_OKAY);
        bk(32'h0000_0001);
        brd.backup(1'b0, 1'b0);
        repeat (10) @(posedge sys_clk);
        rd(`RSMC_OFS_STATUS, 32'h0000_0002, `RSMC_RESP_OKAY);
        bk(32'h0000_0002);
        cfg(32'h0000_0001);
        brd.backup(1'b1, 1'b1);
        repeat (10) @(posedge sys_clk);
        rd(`RSMC_OFS_STATUS, 32'h0000_0000, `RSMC_RESP_OKAY);
        bk(32'h0000_0000);
    endtask
    task automatic t_bus;
        int n;
        logic aw_ok, w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge sys_clk);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge sys_clk);
            n++;
            if (s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
                aw_ok = 1'b1;
            end
            if (s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
                w_ok = 1'b1;
            end
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        chk("awready", 32'h0000_0001, {31'h0, aw_ok});
        chk("wready", 32'h0000_0001, {31'h0, w_ok});
        chk("bvalid", 32'h0000_0001, {31'h0, s_axi_bvalid});
        chk("bresp", 32'h0000_0002, {30'h0, s_axi_bresp});
        cfg(32'h0000_0001);
        rd(8'h0c, 32'h0000_0000, `RSMC_RESP_SLVERR);
    endtask
    task automatic results;
        if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        t_cfg;
        t_hold;
        t_bk;
        t_bus;
        results;
    end
    initial begin
        repeat (5000) @(posedge sys_clk);
        error_cnt++;
        results;
    end
endmodule // reset_strap_mode_capture_tb_top
`default_nettype wire
